// ### design/pasr_defs.svh
// register offsets, field positions, reset values for the shutdown block
`ifndef PASR_DEFS_SVH
`define PASR_DEFS_SVH
`define PASR_OFS_SHUTDOWN_CTRL 12'h000
`define PASR_OFS_PWM_CTRL 12'h004
`define PASR_OFS_IRQ_STATUS 12'h008
`define PASR_OFS_IRQ_MASK 12'h00c
`define PASR_OFS_LIVE 12'h010
`define PASR_BIT_EVENT_STATUS 7
`define PASR_SEL_HI 6
`define PASR_SEL_LO 4
`define PASR_AC_HI 3
`define PASR_AC_LO 2
`define PASR_BD_HI 1
`define PASR_BD_LO 0
`define PASR_BIT_AUTO_RESTART 7
`define PASR_IRQ_SHUTDOWN 0
`define PASR_IRQ_RESTART 1
`define PASR_IRQ_W 2
`define PASR_RST_SHUTDOWN_CTRL 8'h00
`define PASR_RST_PWM_CTRL 8'h00
`define PASR_RST_IRQ_MASK 2'h0
`define PASR_SYNC_STAGES 2
`endif

// ### design/pasr_if.sv
// carrier between the control core and the pin forcing stage
`timescale 1ns/100ps
interface pasr_if;
   import pasr_pkg::*;
   pasr_src_sel_type sel;
   pasr_safe_type safe_ac;
   pasr_safe_type safe_bd;
   logic hold;
   logic int_pin_n;
   logic cmp_one;
   logic cmp_two;
   logic [3:0] pwm_in;
   logic [3:0] pwm_en;
   logic [3:0] pin_out;
   logic [3:0] pin_oe;
   modport core (output sel, output safe_ac, output safe_bd, output hold, output int_pin_n,
                 output cmp_one, output cmp_two, output pwm_in, output pwm_en,
                 input pin_out, input pin_oe);
   modport pins (input sel, input safe_ac, input safe_bd, input hold, input int_pin_n,
                 input cmp_one, input cmp_two, input pwm_in, input pwm_en,
                 output pin_out, output pin_oe);
endinterface : pasr_if

// ### design/pasr_pins.sv
// asynchronous forcing of the four pwm pins into their safe states
`timescale 1ns/100ps
module pasr_pins (
   pasr_if.pins bus
);
   import pasr_pkg::*;
   wire raw_cond;
   wire force_safe;

   // raw pins bypass the synchroniser so the pins react without a clock edge
   assign raw_cond = pasr_cond(bus.sel, bus.int_pin_n, bus.cmp_one, bus.cmp_two);
   assign force_safe = bus.hold | raw_cond;

   // pins a (0) and c (2) form one pair, b (1) and d (3) the other
   genvar i;
   for (i = 0; i < 4; i++) begin : g_pin
      wire pasr_safe_type safe = (i % 2 == 0) ? bus.safe_ac : bus.safe_bd;
      assign bus.pin_out[i] = force_safe ? safe[0] : bus.pwm_in[i];
      assign bus.pin_oe[i] = bus.pwm_en[i] & ~(force_safe & safe[1]);
   end
endmodule : pasr_pins

// ### design/pasr_pkg.sv
// types and shared decode for the pwm auto-shutdown block
package pasr_pkg;
   typedef logic [2:0] pasr_src_sel_type;
   typedef logic [1:0] pasr_safe_type;
   typedef enum logic [1:0] {out_running, out_shut, out_wait_period} pasr_out_state_type;

   // source select decode; int pin is active low
   function automatic logic pasr_cond(input pasr_src_sel_type sel, input logic int_n,
                                      input logic c1, input logic c2);
      logic cmp;
      cmp = (sel[0] & c1) | (sel[1] & c2);
      pasr_cond = cmp | (sel[2] & ~int_n);
   endfunction : pasr_cond
endpackage : pasr_pkg

// ### design/pasr_sync.sv
// two-flop synchroniser for asynchronous shutdown sources
`timescale 1ns/100ps
module pasr_sync #(
   parameter int WIDTH = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_val,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] hold_reg;
   logic [WIDTH-1:0] seed_reg;

   initial begin
      if (WIDTH < 1) $error("pasr_sync: WIDTH must be at least 1");
   end

   assign meta_next = async_in;
   assign sync_out = hold_reg;

   // reset value is a port, so it is loaded after release, not under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         hold_reg <= '0;
         seed_reg <= '0;
      end else begin
         seed_reg <= '1;
         meta_reg <= meta_next;
         hold_reg <= (&seed_reg) ? meta_reg : reset_val;
      end
   end
endmodule : pasr_sync

// ### design/pasr_top.sv
// pwm auto-shutdown and auto-restart control with apb registers
`timescale 1ns/100ps
`include "pasr_defs.svh"
module pasr_top #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic int_pin_n,
   input wire logic comparator_one,
   input wire logic comparator_two,
   input wire logic [3:0] pwm_in,
   input wire logic [3:0] pwm_pin_en,
   input wire logic period_start,
   output logic pwm_out_a,
   output logic pwm_out_b,
   output logic pwm_out_c,
   output logic pwm_out_d,
   output logic pwm_oe_a,
   output logic pwm_oe_b,
   output logic pwm_oe_c,
   output logic pwm_oe_d,
   output logic irq
);
   import pasr_pkg::*;

   initial begin
      if (ADDR_W < 5) $error("pasr_top: ADDR_W must be at least 5");
   end

   // register state
   logic [7:0] shutdown_control_reg;
   logic [7:0] shutdown_control_next;
   logic [7:0] pwm_control_reg;
   logic [7:0] pwm_control_next;
   logic [`PASR_IRQ_W-1:0] irq_status_reg;
   logic [`PASR_IRQ_W-1:0] irq_status_next;
   logic [`PASR_IRQ_W-1:0] irq_mask_reg;
   logic [`PASR_IRQ_W-1:0] irq_mask_next;
   logic irq_reg;
   logic irq_next;
   pasr_out_state_type state_reg;
   pasr_out_state_type state_next;
   logic hold_reg;
   logic hold_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;

   // synchronised sources
   wire [2:0] src_sync;
   wire int_n_s = src_sync[0];
   wire c1_s = src_sync[1];
   wire c2_s = src_sync[2];

   pasr_sync #(.WIDTH(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({comparator_two, comparator_one, int_pin_n}),
      .reset_val(3'h1),
      .sync_out(src_sync)
   );

   pasr_if pin_bus ();
   pasr_pins u_pins (
      .bus(pin_bus.pins)
   );

   // control fields
   wire pasr_src_sel_type sel = shutdown_control_reg[`PASR_SEL_HI:`PASR_SEL_LO];
   wire pasr_safe_type safe_ac = shutdown_control_reg[`PASR_AC_HI:`PASR_AC_LO];
   wire pasr_safe_type safe_bd = shutdown_control_reg[`PASR_BD_HI:`PASR_BD_LO];
   wire event_status = shutdown_control_reg[`PASR_BIT_EVENT_STATUS];
   wire auto_restart_enable = pwm_control_reg[`PASR_BIT_AUTO_RESTART];

   assign pin_bus.sel = sel;
   assign pin_bus.safe_ac = safe_ac;
   assign pin_bus.safe_bd = safe_bd;
   assign pin_bus.hold = hold_reg;
   assign pin_bus.int_pin_n = int_pin_n;
   assign pin_bus.cmp_one = comparator_one;
   assign pin_bus.cmp_two = comparator_two;
   assign pin_bus.pwm_in = pwm_in;
   assign pin_bus.pwm_en = pwm_pin_en;

   // pins are forced combinationally from raw sources, so they cannot come from flops
   assign pwm_out_a = pin_bus.pin_out[0];
   assign pwm_out_b = pin_bus.pin_out[1];
   assign pwm_out_c = pin_bus.pin_out[2];
   assign pwm_out_d = pin_bus.pin_out[3];
   assign pwm_oe_a = pin_bus.pin_oe[0];
   assign pwm_oe_b = pin_bus.pin_oe[1];
   assign pwm_oe_c = pin_bus.pin_oe[2];
   assign pwm_oe_d = pin_bus.pin_oe[3];

   // condition from synchronised sources; level, not edge
   wire cond = pasr_cond(sel, int_n_s, c1_s, c2_s);

   // apb decode; one wait state, writes land on the completing edge
   wire access = psel & penable;
   wire done = access & pready_reg;
   wire wr = done & pwrite;
   wire rd = done & ~pwrite;
   wire [ADDR_W-1:0] ofs = paddr;
   wire hit_ctrl = (ofs == ADDR_W'(`PASR_OFS_SHUTDOWN_CTRL));
   wire hit_pwm = (ofs == ADDR_W'(`PASR_OFS_PWM_CTRL));
   wire hit_irqs = (ofs == ADDR_W'(`PASR_OFS_IRQ_STATUS));
   wire hit_mask = (ofs == ADDR_W'(`PASR_OFS_IRQ_MASK));
   wire hit_live = (ofs == ADDR_W'(`PASR_OFS_LIVE));
   wire hit_any = hit_ctrl | hit_pwm | hit_irqs | hit_mask | hit_live;
   wire wr_ctrl = wr & hit_ctrl;

   // status bit: hardware set wins over every clear
   wire fw_set = wr_ctrl & pwdata[`PASR_BIT_EVENT_STATUS] & ~cond;
   wire fw_clr = wr_ctrl & ~pwdata[`PASR_BIT_EVENT_STATUS] & ~cond;
   wire hw_clr = auto_restart_enable & ~cond;
   wire status_next = cond | fw_set | (event_status & ~fw_clr & ~hw_clr);

   assign shutdown_control_next = wr_ctrl ? {status_next, pwdata[6:0]} :
                                  {status_next, shutdown_control_reg[6:0]};
   assign pwm_control_next = (wr & hit_pwm) ? {pwdata[7], 7'h00} : pwm_control_reg;
   assign irq_mask_next = (wr & hit_mask) ? pwdata[`PASR_IRQ_W-1:0] : irq_mask_reg;

   // output release state: restart waits for a period boundary
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         out_running: begin
            if (status_next) state_next = out_shut;
         end
         out_shut: begin
            if (!status_next) state_next = out_wait_period;
         end
         out_wait_period: begin
            if (status_next) state_next = out_shut;
            else if (period_start) state_next = out_running;
         end
         default: begin
            state_next = out_shut;
         end
      endcase
   end

   assign hold_next = (state_next != out_running);

   // sticky events; a read clears only the bits it returned, so an event that lands
   // between the data capture and the completing edge is kept for the next read
   wire ev_shut = (state_reg == out_running) & (state_next != out_running);
   wire ev_restart = (state_reg != out_running) & (state_next == out_running);
   wire [`PASR_IRQ_W-1:0] ev = {ev_restart, ev_shut};
   wire [`PASR_IRQ_W-1:0] irq_shown = prdata_reg[`PASR_IRQ_W-1:0];
   wire [`PASR_IRQ_W-1:0] irq_kept = (rd & hit_irqs) ? (irq_status_reg & ~irq_shown) :
                                     irq_status_reg;
   assign irq_status_next = irq_kept | ev;
   assign irq_next = |(irq_status_next & irq_mask_next);

   // read data captured at the wait cycle, shown with pready
   wire [31:0] live_word = {27'h0, hold_reg, cond, c2_s, c1_s, ~int_n_s};
   always_comb begin
      prdata_next = prdata_reg;
      if (access & ~pready_reg & ~pwrite) begin
         prdata_next = 32'h0;
         if (hit_ctrl) prdata_next = {24'h0, shutdown_control_reg};
         if (hit_pwm) prdata_next = {24'h0, pwm_control_reg};
         if (hit_irqs) prdata_next = {30'h0, irq_status_reg};
         if (hit_mask) prdata_next = {30'h0, irq_mask_reg};
         if (hit_live) prdata_next = live_word;
      end
   end

   assign pready_next = access & ~pready_reg;
   assign pslverr_next = access & ~pready_reg & ~hit_any;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shutdown_control_reg <= `PASR_RST_SHUTDOWN_CTRL;
         pwm_control_reg <= `PASR_RST_PWM_CTRL;
         irq_status_reg <= '0;
         irq_mask_reg <= `PASR_RST_IRQ_MASK;
         irq_reg <= 1'b0;
         state_reg <= out_running;
         hold_reg <= 1'b0;
      end else begin
         shutdown_control_reg <= shutdown_control_next;
         pwm_control_reg <= pwm_control_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         irq_reg <= irq_next;
         state_reg <= state_next;
         hold_reg <= hold_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
endmodule : pasr_top

// ### dv/pasr_bridge_model.sv
// far side model: fault sources and pwm generator
`timescale 1ns/100ps
module pasr_bridge_model #(
   parameter int PERIOD = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] fault,
   output logic int_pin_n,
   output logic comparator_one,
   output logic comparator_two,
   output logic [3:0] pwm_in,
   output logic period_start
);
   logic [7:0] cnt_reg;
   // fault bit0 c1 high, bit1 c2 high, bit2 int pin low
   assign comparator_one = fault[0];
   assign comparator_two = fault[1];
   assign int_pin_n = ~fault[2];
   // waveform changes every cycle so a stale pin shows
   assign pwm_in = cnt_reg[3:0];
   assign period_start = (cnt_reg == 8'h00);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_reg <= 8'h00;
      else cnt_reg <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
   end
endmodule : pasr_bridge_model

// ### dv/pasr_top_chk.sv
// port checks for the shutdown block
`timescale 1ns/100ps
module pasr_top_chk #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic int_pin_n,
   input wire logic comparator_one,
   input wire logic comparator_two,
   input wire logic [3:0] pwm_pin_en,
   input wire logic pwm_out_a,
   input wire logic pwm_out_b,
   input wire logic pwm_oe_a,
   input wire logic pwm_oe_b,
   input wire logic pwm_oe_c,
   input wire logic pwm_oe_d,
   input wire logic irq
);
   logic [6:0] ctrl_reg;
   logic cond;
   // shadow of select and safe fields; status bit left out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_reg <= 7'h00;
      else if (psel & penable & pready & pwrite & ~pslverr & (paddr == '0))
         ctrl_reg <= pwdata[6:0];
   end
   assign cond = (ctrl_reg[4] & comparator_one) | (ctrl_reg[5] & comparator_two)
      | (ctrl_reg[6] & ~int_pin_n);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_second: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_ready_idle: assert property (!psel |-> !pready) else $error("pready without select");
   a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("error read not zero");
   a_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
      else $error("unmapped access not refused");
   a_ac_drive: assert property (
      cond && !ctrl_reg[3] && pwm_pin_en[0] |-> pwm_oe_a && pwm_out_a == ctrl_reg[2])
      else $error("pair a/c not at safe level");
   a_ac_float: assert property (cond && ctrl_reg[3] |-> !pwm_oe_a && !pwm_oe_c)
      else $error("pair a/c still driven");
   a_bd_drive: assert property (
      cond && !ctrl_reg[1] && pwm_pin_en[1] |-> pwm_oe_b && pwm_out_b == ctrl_reg[0])
      else $error("pair b/d not at safe level");
   a_bd_float: assert property (cond && ctrl_reg[1] |-> !pwm_oe_b && !pwm_oe_d)
      else $error("pair b/d still driven");
   a_pin_off: assert property (!pwm_pin_en[2] |-> !pwm_oe_c)
      else $error("disabled pin driven");
   c_float: cover property (cond && ctrl_reg[3]);
   c_refused: cover property (pready && pslverr);
   c_irq_clear: cover property ($fell(irq));
endmodule : pasr_top_chk

// ### dv/pasr_top_tb.sv
// self-checking bench for the pwm auto-shutdown block
`timescale 1ns/100ps
module pasr_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ps, err;
   logic ic, c1, c2;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pwm_in, en;
   logic [2:0] fault;
   wire [3:0] po, oe;
   int errors, total_checks;
   pasr_top u_pasr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .int_pin_n(ic), .comparator_one(c1), .comparator_two(c2),
      .pwm_in(pwm_in), .pwm_pin_en(en), .period_start(ps), .pwm_out_a(po[0]),
      .pwm_out_b(po[1]), .pwm_out_c(po[2]), .pwm_out_d(po[3]), .pwm_oe_a(oe[0]),
      .pwm_oe_b(oe[1]), .pwm_oe_c(oe[2]), .pwm_oe_d(oe[3]), .irq(irq));
   pasr_bridge_model u_pasr_bridge_model (.pclk(pclk), .presetn(presetn), .fault(fault),
      .int_pin_n(ic), .comparator_one(c1), .comparator_two(c2), .pwm_in(pwm_in),
      .period_start(ps));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // entered right after an edge; leaves an idle cycle so psel is never set twice at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // answer and read data taken at the rising edge that completes the access
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   task automatic lvl(input logic e);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, e});
      @(posedge pclk);
   endtask : lvl
   task automatic period();
      do @(negedge pclk); while (ps !== 1'b1);
      @(posedge pclk);
   endtask : period
   task automatic pins(input logic sh, input logic [1:0] ac, input logic [1:0] bd);
      logic [3:0] eo, ee;
      @(negedge pclk);
      eo = pwm_in;
      ee = en;
      if (sh) begin
         eo = {bd[0], ac[0], bd[0], ac[0]};
         ee = {~bd[1], ~ac[1], ~bd[1], ~ac[1]} & en;
      end
      chk({28'h0, oe}, {28'h0, ee});
      chk({28'h0, po & ee}, {28'h0, eo & ee});
      @(posedge pclk);
   endtask : pins
   task automatic end_sim();
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #50000;
      errors++;
      end_sim();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, fault, en} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(12'h000, 32'h0);
      rdc(12'h004, 32'h0);
      rdc(12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 12'h00c, 32'h1);
      for (int s = 1; s < 8; s++) begin
         logic [1:0] ac, bd;
         ac = s[1:0];
         bd = ~s[1:0];
         en <= s[0] ? 4'hb : 4'hf;
         apb(1'b1, 12'h000, {25'h0, s[2:0], ac, bd});
         fault <= ~s[2:0];
         pins(1'b0, ac, bd);
         fault <= s[2:0] & (~s[2:0] + 3'h1);
         pins(1'b1, ac, bd);
         repeat (4) @(posedge pclk);
         rdc(12'h000, {24'h0, 1'b1, s[2:0], ac, bd});
         lvl(1'b1);
         apb(1'b1, 12'h000, {25'h0, s[2:0], ac, bd});
         rdc(12'h000, {24'h0, 1'b1, s[2:0], ac, bd});
         fault <= 3'h0;
         repeat (4) @(posedge pclk);
         rdc(12'h000, {24'h0, 1'b1, s[2:0], ac, bd});
         period();
         apb(1'b1, 12'h000, {25'h0, s[2:0], ac, bd});
         pins(1'b1, ac, bd);
         period();
         pins(1'b0, ac, bd);
         rdc(12'h008, 32'h3);
         lvl(1'b0);
      end
      apb(1'b1, 12'h004, 32'h80);
      fault <= 3'h1;
      repeat (6) @(posedge pclk);
      rdc(12'h000, 32'hfc);
      rdc(12'h010, 32'h1a);
      fault <= 3'h0;
      repeat (5) @(posedge pclk);
      rdc(12'h000, 32'h7c);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h8c);
      pins(1'b1, 2'b11, 2'b00);
      rdc(12'h000, 32'h8c);
      // reset in mid-run: a forced shutdown and its status must not survive
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      pins(1'b0, 2'b00, 2'b00);
      rdc(12'h000, 32'h0);
      lvl(1'b0);
      end_sim();
   end
endmodule : pasr_top_tb
bind pasr_top pasr_top_chk #(.ADDR_W(ADDR_W)) u_pasr_top_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .int_pin_n(int_pin_n), .comparator_one(comparator_one),
   .comparator_two(comparator_two), .pwm_pin_en(pwm_pin_en), .pwm_out_a(pwm_out_a),
   .pwm_out_b(pwm_out_b), .pwm_oe_a(pwm_oe_a), .pwm_oe_b(pwm_oe_b), .pwm_oe_c(pwm_oe_c),
   .pwm_oe_d(pwm_oe_d), .irq(irq));
